//--- hw/rsc_pkg.sv
/*
 * shared constants and types of the reader synchronisation controller.
 * assumes a single 250 MHz system clock and a synchronous active-high reset.
 */
package rsc_pkg;
    localparam int CLK_MHZ = 250;
    // back-off time, microseconds
    localparam int BACKOFF_US = 20;
    localparam int BACKOFF_CYC = BACKOFF_US * CLK_MHZ;
    // width of the emitted sync pulse, nanoseconds; least time, rounded up
    localparam int SYNC_PULSE_NS = 1000;
    localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;

    typedef enum logic [2:0] {
        RSC_MODE_NONE     = 3'h0,
        RSC_MODE_WIRELESS = 3'h1,
        RSC_MODE_WIRED    = 3'h2,
        RSC_MODE_COMBINED = 3'h3,
        RSC_MODE_MS_NOACK = 3'h4,
        RSC_MODE_MS_ACK   = 3'h5,
        RSC_MODE_TRIG     = 3'h6
    } rsc_mode_t;

    typedef enum logic [4:0] {
        RSC_ST_IDLE     = 5'h01,
        RSC_ST_BACKOFF  = 5'h02,
        RSC_ST_WAIT_SYN = 5'h04,
        RSC_ST_ACTIVE   = 5'h08,
        RSC_ST_WAIT_ACK = 5'h10
    } rsc_state_t;
endpackage

//--- hw/rsc_sync_ctrl.sv
/*
 * reader synchronisation controller: decides when the radio may start a
 * read/write cycle under the selected scheme and drives the sync, ack and
 * carrier-phase lines.
 * assumes all inputs are synchronous to clk; differential line drivers and
 * receivers sit outside and present single-ended levels here.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_sync_ctrl #(
    parameter logic [rsc_pkg::CNT_W-1:0] BACKOFF_CYCLES = rsc_pkg::CNT_W'(rsc_pkg::BACKOFF_CYC)
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // configuration
    input  wire rsc_pkg::rsc_mode_t  sync_mode,
    input  wire logic                ms_master,
    input  wire logic                trig_source,
    input  wire logic                cps_enable,
    input  wire logic                cps_slave,
    // radio task handshake
    input  wire logic                cycle_req,
    input  wire logic                task_is_write,
    input  wire logic                cycle_done,
    output logic                     cycle_start,
    output logic                     cycle_active,
    output logic                     task_refused,
    output logic                     cfg_conflict,
    // wireless detection
    input  wire logic                rx_above_thresh,
    // sync pair
    input  wire logic                sync_rx,
    output logic                     sync_tx,
    // acknowledge pair
    input  wire logic                ack_rx,
    output logic                     ack_tx,
    // carrier phase
    input  wire logic                osc_local,
    input  wire logic                cps_rx,
    output logic                     cps_tx,
    output logic                     cps_tx_oe,
    output logic                     tx_osc
);
    import rsc_pkg::*;

    function automatic logic uses_wireless(input rsc_mode_t m);
        return (m == RSC_MODE_WIRELESS) || (m == RSC_MODE_COMBINED);
    endfunction

    function automatic logic uses_wired(input rsc_mode_t m);
        return (m == RSC_MODE_WIRED) || (m == RSC_MODE_COMBINED);
    endfunction

    function automatic logic is_ms(input rsc_mode_t m);
        return (m == RSC_MODE_MS_NOACK) || (m == RSC_MODE_MS_ACK);
    endfunction

    // cycle state
    rsc_state_t       state;
    rsc_state_t       next_state;
    logic             sync_rx_q;
    logic             sync_rise;
    logic             other_busy;
    logic             bo_load;
    logic             bo_running;
    logic             bo_expired;
    logic             next_cycle_start;
    logic             next_task_refused;
    logic             next_pulse_go;

    // sync pulse generator
    logic [CNT_W-1:0] pulse_cnt;
    logic [CNT_W-1:0] next_pulse_cnt;

    // line outputs
    logic             next_sync_tx;
    logic             next_ack_tx;
    logic             next_cycle_active;
    logic             next_cfg_conflict;
    logic             cps_on;
    logic             next_cps_tx;
    logic             next_cps_tx_oe;
    logic             next_tx_osc;

    assign sync_rise = sync_rx && !sync_rx_q;

    // presence of another reader, from antenna, wired pair, or both
    always_comb begin
        other_busy = 1'b0;
        if (uses_wireless(sync_mode) && rx_above_thresh) begin
            other_busy = 1'b1;
        end
        if (uses_wired(sync_mode) && sync_rx) begin
            other_busy = 1'b1;
        end
    end

    rsc_timer u_backoff (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (bo_load),
        .load_val (BACKOFF_CYCLES),
        .running  (bo_running),
        .expired  (bo_expired)
    );

    always_comb begin
        next_state        = state;
        next_cycle_start  = 1'b0;
        next_task_refused = 1'b0;
        next_pulse_go     = 1'b0;
        bo_load           = 1'b0;
        case (state)
            RSC_ST_IDLE: begin
                if (cycle_req) begin
                    case (sync_mode)
                        RSC_MODE_NONE: begin
                            next_cycle_start = 1'b1;
                            next_state       = RSC_ST_ACTIVE;
                        end
                        RSC_MODE_WIRELESS, RSC_MODE_WIRED, RSC_MODE_COMBINED: begin
                            if (uses_wireless(sync_mode) && task_is_write) begin
                                next_task_refused = 1'b1;
                            end else if (other_busy) begin
                                bo_load    = 1'b1;
                                next_state = RSC_ST_BACKOFF;
                            end else begin
                                next_cycle_start = 1'b1;
                                next_state       = RSC_ST_ACTIVE;
                            end
                        end
                        RSC_MODE_MS_NOACK, RSC_MODE_MS_ACK: begin
                            if (!ms_master) begin
                                next_state = RSC_ST_WAIT_SYN;
                            end else if (sync_mode == RSC_MODE_MS_ACK && ack_rx) begin
                                next_state = RSC_ST_WAIT_ACK;
                            end else begin
                                next_pulse_go    = 1'b1;
                                next_cycle_start = 1'b1;
                                next_state       = RSC_ST_ACTIVE;
                            end
                        end
                        RSC_MODE_TRIG: begin
                            if (trig_source) begin
                                next_pulse_go    = 1'b1;
                                next_cycle_start = 1'b1;
                                next_state       = RSC_ST_ACTIVE;
                            end else begin
                                next_state = RSC_ST_WAIT_SYN;
                            end
                        end
                        default: begin
                            next_task_refused = 1'b1;
                        end
                    endcase
                end
            end
            RSC_ST_BACKOFF: begin
                // re-arbitrate once the delay has run out
                if (bo_expired || !bo_running) begin
                    next_state = RSC_ST_IDLE;
                end
            end
            RSC_ST_WAIT_SYN: begin
                if (!cycle_req) begin
                    next_state = RSC_ST_IDLE;
                end else if (sync_rise) begin
                    next_cycle_start = 1'b1;
                    next_state       = RSC_ST_ACTIVE;
                end
            end
            RSC_ST_ACTIVE: begin
                if (cycle_done) begin
                    if (sync_mode == RSC_MODE_MS_ACK && ms_master) begin
                        next_state = RSC_ST_WAIT_ACK;
                    end else begin
                        next_state = RSC_ST_IDLE;
                    end
                end
            end
            RSC_ST_WAIT_ACK: begin
                // slaves hold ack_rx high while any of them is still busy
                if (!ack_rx && pulse_cnt == '0) begin
                    next_state = RSC_ST_IDLE;
                end
            end
            default: begin
                next_state = RSC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state        <= RSC_ST_IDLE;
            sync_rx_q    <= 1'b0;
            cycle_start  <= 1'b0;
            task_refused <= 1'b0;
        end else begin
            state        <= next_state;
            sync_rx_q    <= sync_rx;
            cycle_start  <= next_cycle_start;
            task_refused <= next_task_refused;
        end
    end

    // sync pulse: fixed width so slaves see a clean rising edge
    always_comb begin
        next_pulse_cnt = pulse_cnt;
        if (next_pulse_go) begin
            next_pulse_cnt = CNT_W'(SYNC_PULSE_CYC);
        end else if (pulse_cnt != '0) begin
            next_pulse_cnt = pulse_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse_cnt <= '0;
        end else begin
            pulse_cnt <= next_pulse_cnt;
        end
    end

    // sync, ack and activity lines
    always_comb begin
        next_cycle_active = (next_state == RSC_ST_ACTIVE);
        next_sync_tx      = 1'b0;
        next_ack_tx       = 1'b0;
        if (uses_wired(sync_mode)) begin
            // peers see our cycle as presence on the wired pair
            next_sync_tx = next_cycle_active;
        end else if (is_ms(sync_mode) || sync_mode == RSC_MODE_TRIG) begin
            next_sync_tx = (next_pulse_cnt != '0);
        end
        if (sync_mode == RSC_MODE_MS_ACK && !ms_master) begin
            // busy on the slave transmit pair until our cycle completes
            next_ack_tx = next_cycle_active;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cycle_active <= 1'b0;
            sync_tx      <= 1'b0;
            ack_tx       <= 1'b0;
        end else begin
            cycle_active <= next_cycle_active;
            sync_tx      <= next_sync_tx;
            ack_tx       <= next_ack_tx;
        end
    end

    // carrier phase: refused while triggered mode is selected
    assign cps_on = cps_enable && (sync_mode != RSC_MODE_TRIG);

    always_comb begin
        next_cfg_conflict = cps_enable && (sync_mode == RSC_MODE_TRIG);
        next_cps_tx       = 1'b0;
        next_cps_tx_oe    = 1'b0;
        next_tx_osc       = osc_local;
        if (cps_on) begin
            if (cps_slave) begin
                next_tx_osc = cps_rx;
            end else begin
                next_cps_tx    = osc_local;
                next_cps_tx_oe = 1'b1;
            end
        end
    end

    // one register stage on the oscillator path; a slave adds its stage to the one
    // already on the master's cps_tx, so its tx_osc lags the master's by a cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_conflict <= 1'b0;
            cps_tx       <= 1'b0;
            cps_tx_oe    <= 1'b0;
            tx_osc       <= 1'b0;
        end else begin
            cfg_conflict <= next_cfg_conflict;
            cps_tx       <= next_cps_tx;
            cps_tx_oe    <= next_cps_tx_oe;
            tx_osc       <= next_tx_osc;
        end
    end
endmodule // rsc_sync_ctrl
`default_nettype wire

//--- hw/rsc_timer.sv
/*
 * loadable down-counter used for the back-off delay.
 * assumes load and count come from the caller's clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_timer (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // control
    input  wire logic                    load,
    input  wire logic [rsc_pkg::CNT_W-1:0] load_val,
    // status
    output logic                         running,
    output logic                         expired
);
    import rsc_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_expired;

    always_comb begin
        next_count   = count;
        next_expired = 1'b0;
        if (load) begin
            next_count = load_val;
        end else if (count != '0) begin
            next_count = count - 1'b1;
            // one-cycle pulse on the last tick
            next_expired = (count == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count   <= '0;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            expired <= next_expired;
        end
    end

    assign running = (count != '0);
endmodule // rsc_timer
`default_nettype wire

//--- tb/rsc_peer.sv
/*
 * neighbouring readers on the sync, ack and carrier-phase lines.
 * assumes the bench commands pulses and busy spells at clock edges.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_peer (
    // bench commands
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic       busy,
    input  wire logic [8:0] ack_len,
    // bus lines
    input  wire logic       sync_tx,
    output logic            sync_rx,
    output logic            ack_rx,
    output logic            cps_rx
);
    logic [8:0] ack_cnt = 9'h000;
    logic       rx_q    = 1'h0;
    logic       tx_q    = 1'h0;
    logic [1:0] ph      = 2'h0;
    // slaves run the same task as the master, so only their busy time matters
    always_ff @(posedge clk) begin
        tx_q <= sync_tx;
        rx_q <= fire | busy;
        if (sync_tx && !tx_q)
            ack_cnt <= ack_len;
        else if (ack_cnt != 9'h000)
            ack_cnt <= ack_cnt - 9'h001;
        ph <= ph + 2'h1;
    end
    assign sync_rx = rx_q;
    assign ack_rx  = (ack_cnt != 9'h000);
    assign cps_rx  = ph[1];
endmodule // rsc_peer
`default_nettype wire

//--- tb/rsc_sync_checker.sv
/*
 * port-level checks of rsc_sync_ctrl.
 * assumes one clock and a synchronous active-high reset; bound at file end.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_sync_checker #(
    parameter logic [rsc_pkg::CNT_W-1:0] BACKOFF_CYCLES = 16'h0008
) (
    // clock and configuration
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire rsc_pkg::rsc_mode_t sync_mode,
    input wire logic               ms_master,
    input wire logic               cps_enable,
    input wire logic               cps_slave,
    // radio handshake
    input wire logic               cycle_req,
    input wire logic               task_is_write,
    input wire logic               cycle_start,
    input wire logic               cycle_active,
    input wire logic               cfg_conflict,
    // bus lines
    input wire logic               rx_above_thresh,
    input wire logic               sync_rx,
    input wire logic               sync_tx,
    input wire logic               ack_rx,
    input wire logic               ack_tx,
    input wire logic               osc_local,
    input wire logic               cps_rx,
    input wire logic               cps_tx,
    input wire logic               cps_tx_oe,
    input wire logic               tx_osc
);
    import rsc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_none_prompt: assert property (
        sync_mode == RSC_MODE_NONE && cycle_req && !cycle_active && !$past(cycle_active)
        |=> cycle_start) else $error("no-sync start late");
    a_sense_backoff: assert property (
        (sync_mode inside {RSC_MODE_WIRELESS, RSC_MODE_COMBINED} && rx_above_thresh) ||
        (sync_mode inside {RSC_MODE_WIRED, RSC_MODE_COMBINED} && sync_rx)
        |=> !cycle_start) else $error("start while another reader active");
    a_write_refused: assert property (
        sync_mode inside {RSC_MODE_WIRELESS, RSC_MODE_COMBINED} && cycle_req && task_is_write
        |=> !cycle_start) else $error("write started under wireless sync");
    a_slave_edge: assert property (
        cycle_start && !ms_master && sync_mode == RSC_MODE_MS_NOACK
        |-> $past(sync_rx) && !$past(sync_rx, 2)) else $error("slave start without pulse");
    a_lead_pulse: assert property (
        cycle_start && ms_master && sync_mode inside {RSC_MODE_MS_NOACK, RSC_MODE_MS_ACK}
        |-> sync_tx [*8]) else $error("master pulse missing");
    a_ack_hold: assert property (
        sync_mode == RSC_MODE_MS_ACK && ms_master && ack_rx |=> !cycle_start)
        else $error("master ran ahead of slaves");
    a_ack_mirror: assert property (
        sync_mode == RSC_MODE_MS_ACK && !ms_master |-> ack_tx == cycle_active)
        else $error("ack line wrong");
    a_cps_trig: assert property (
        sync_mode == RSC_MODE_TRIG && cps_enable |=> cfg_conflict && !cps_tx_oe)
        else $error("carrier share with trigger");
    a_cps_src: assert property (
        cps_enable && !cps_slave && sync_mode != RSC_MODE_TRIG
        |=> cps_tx_oe && cps_tx == $past(osc_local)) else $error("bus oscillator wrong");
    a_cps_take: assert property (
        cps_enable && cps_slave && sync_mode != RSC_MODE_TRIG
        |=> !cps_tx_oe && tx_osc == $past(cps_rx)) else $error("shared oscillator unused");

    c_backoff: cover property (sync_mode == RSC_MODE_WIRELESS && rx_above_thresh && cycle_req);
    c_ack_wait: cover property (sync_mode == RSC_MODE_MS_ACK && ack_rx && cycle_req);
    c_slave: cover property (cycle_start && !ms_master);
endmodule // rsc_sync_checker

bind rsc_sync_ctrl rsc_sync_checker #(.BACKOFF_CYCLES(BACKOFF_CYCLES)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .sync_mode(sync_mode), .ms_master(ms_master),
    .cps_enable(cps_enable), .cps_slave(cps_slave), .cycle_req(cycle_req),
    .task_is_write(task_is_write), .cycle_start(cycle_start), .cycle_active(cycle_active),
    .cfg_conflict(cfg_conflict), .rx_above_thresh(rx_above_thresh), .sync_rx(sync_rx),
    .sync_tx(sync_tx), .ack_rx(ack_rx), .ack_tx(ack_tx), .osc_local(osc_local),
    .cps_rx(cps_rx), .cps_tx(cps_tx), .cps_tx_oe(cps_tx_oe), .tx_osc(tx_osc));
`default_nettype wire

//--- tb/tb.sv
/*
 * self-checking bench for rsc_sync_ctrl with a peer model.
 * assumes the checker is bound to the design; short back-off of 8 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("FAIL %0t got %h exp %h", $time, a, b); end end
module tb;
    import rsc_pkg::*;
    localparam int BOI = 8;
    logic       clk = 1'h0, sys_rst = 1'h1, osc_local = 1'h0;
    rsc_mode_t  sync_mode = RSC_MODE_NONE;
    logic       ms_master = 1'h0, trig_source = 1'h0, cps_enable = 1'h0, cps_slave = 1'h0;
    logic       cycle_req = 1'h0, task_is_write = 1'h0, cycle_done = 1'h0;
    logic       rx_above_thresh = 1'h0, fire = 1'h0, busy = 1'h0;
    logic [8:0] ack_len = 9'h000;
    logic       cycle_start, cycle_active, task_refused, cfg_conflict, sync_rx, sync_tx;
    logic       ack_rx, ack_tx, cps_rx, cps_tx, cps_tx_oe, tx_osc;
    int         fail_count = 0, tests_run = 0, cyc = 0;

    rsc_sync_ctrl #(.BACKOFF_CYCLES(16'h0008)) dut (.clk(clk), .sys_rst(sys_rst),
        .sync_mode(sync_mode), .ms_master(ms_master), .trig_source(trig_source),
        .cps_enable(cps_enable), .cps_slave(cps_slave), .cycle_req(cycle_req),
        .task_is_write(task_is_write), .cycle_done(cycle_done), .cycle_start(cycle_start),
        .cycle_active(cycle_active), .task_refused(task_refused), .cfg_conflict(cfg_conflict),
        .rx_above_thresh(rx_above_thresh), .sync_rx(sync_rx), .sync_tx(sync_tx),
        .ack_rx(ack_rx), .ack_tx(ack_tx), .osc_local(osc_local), .cps_rx(cps_rx),
        .cps_tx(cps_tx), .cps_tx_oe(cps_tx_oe), .tx_osc(tx_osc));
    rsc_peer peer (.clk(clk), .fire(fire), .busy(busy), .ack_len(ack_len),
        .sync_tx(sync_tx), .sync_rx(sync_rx), .ack_rx(ack_rx), .cps_rx(cps_rx));

    initial forever #2 clk = ~clk;
    always @(posedge clk) osc_local <= ~osc_local;
    // the whole run needs about 1000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cfg(input rsc_mode_t m, input logic mst, trg, cen, csl);
        @(posedge clk);
        sync_mode <= m;
        ms_master <= mst;
        trig_source <= trg;
        cps_enable <= cen;
        cps_slave <= csl;
    endtask
    task automatic put(input rsc_mode_t m, input logic w);
        @(posedge clk);
        sync_mode <= m;
        task_is_write <= w;
        cycle_req <= 1'h1;
    endtask
    // request stays up until the start is seen, then drops on the next edge
    task automatic wait_start(input int lim, output int n);
        n = 0;
        do begin
            go(1);
            n++;
        end while (cycle_start !== 1'h1 && n < lim);
        @(posedge clk);
        cycle_req <= 1'h0;
    endtask
    task automatic finish();
        @(posedge clk);
        cycle_done <= 1'h1;
        @(posedge clk);
        cycle_done <= 1'h0;
        #1;
        `CHK(cycle_active, 1'h0)
    endtask
    task automatic t_none();
        int n;
        put(RSC_MODE_NONE, 1'h0);
        busy <= 1'h1;
        rx_above_thresh <= 1'h1;
        wait_start(4, n);
        busy <= 1'h0;
        rx_above_thresh <= 1'h0;
        `CHK(n == 1, 1'h1)
        finish();
    endtask
    task automatic t_write();
        rsc_mode_t ms[5] = '{RSC_MODE_NONE, RSC_MODE_WIRELESS, RSC_MODE_WIRED,
                             RSC_MODE_COMBINED, rsc_mode_t'(3'h7)};
        logic r;
        foreach (ms[i]) begin
            r = (i == 1 || i == 3 || i == 4);
            put(ms[i], 1'h1);
            go(2);
            `CHK(task_refused, r)
            `CHK(cycle_active, !r)
            @(posedge clk);
            cycle_req <= 1'h0;
            if (!r) finish();
            go(2);
        end
    endtask
    task automatic t_busy(input rsc_mode_t m, input logic wired);
        int n;
        @(posedge clk);
        busy <= wired;
        rx_above_thresh <= !wired;
        @(posedge clk);
        put(m, 1'h0);
        @(posedge clk);
        busy <= 1'h0;
        rx_above_thresh <= 1'h0;
        wait_start(4 * BOI, n);
        `CHK(n >= BOI + 1 && n <= BOI + 4, 1'h1)
        finish();
    endtask
    task automatic t_lead(input rsc_mode_t m);
        int n, k;
        cfg(m, 1'h1, 1'h1, 1'h0, 1'h0);
        put(m, 1'h0);
        wait_start(4, n);
        `CHK(n == 1, 1'h1)
        k = 1;
        #1;
        while (sync_tx === 1'h1 && k < 400) begin
            k++;
            go(1);
        end
        `CHK(k == SYNC_PULSE_CYC, 1'h1)
        finish();
    endtask
    task automatic t_follow(input rsc_mode_t m, input logic mst);
        int n;
        // the waiting unit is configured and its task set before the pulse source fires
        cfg(m, mst, 1'h0, 1'h0, 1'h0);
        put(m, 1'h0);
        go(6);
        `CHK(cycle_active, 1'h0)
        @(posedge clk);
        fire <= 1'h1;
        wait_start(8, n);
        fire <= 1'h0;
        `CHK(n >= 2 && n <= 3, 1'h1)
        #1;
        `CHK(ack_tx, m == RSC_MODE_MS_ACK)
        finish();
    endtask
    task automatic t_ack();
        int n;
        cfg(RSC_MODE_MS_ACK, 1'h1, 1'h0, 1'h0, 1'h0);
        ack_len <= 9'h12c;
        put(RSC_MODE_MS_ACK, 1'h0);
        wait_start(4, n);
        finish();
        put(RSC_MODE_MS_ACK, 1'h0);
        wait_start(400, n);
        `CHK(n > 260 && n < 340, 1'h1)
        finish();
    endtask
    task automatic t_cps();
        logic p;
        cfg(RSC_MODE_TRIG, 1'h1, 1'h1, 1'h1, 1'h0);
        go(2);
        `CHK(cfg_conflict, 1'h1)
        `CHK(cps_tx_oe, 1'h0)
        for (int s = 0; s < 2; s++) begin
            cfg(RSC_MODE_NONE, 1'h0, 1'h0, 1'h1, s[0]);
            go(2);
            repeat (4) begin
                p = s[0] ? cps_rx : osc_local;
                go(1);
                `CHK(tx_osc, p)
                `CHK(cps_tx_oe, !s[0])
            end
        end
    endtask

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'h0;
        t_none();
        t_write();
        t_busy(RSC_MODE_WIRELESS, 1'h0);
        t_busy(RSC_MODE_WIRED, 1'h1);
        t_busy(RSC_MODE_COMBINED, 1'h0);
        t_busy(RSC_MODE_COMBINED, 1'h1);
        t_lead(RSC_MODE_MS_NOACK);
        t_lead(RSC_MODE_TRIG);
        t_follow(RSC_MODE_MS_NOACK, 1'h0);
        t_follow(RSC_MODE_TRIG, 1'h1);
        t_follow(RSC_MODE_MS_ACK, 1'h0);
        t_ack();
        t_cps();
        test_done();
    end
endmodule // tb
`default_nettype wire
